// ===== shared/lcts_pkg.sv
// Purpose: shared constants and types for the teach sequencer of a beam array receiver
// Assumes: 200 MHz system clock, classic Wishbone register access, 16 beams
// Notes: every offset, reset value and timing count is named here once
package lcts_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int LCTS_CLK_KHZ = 200000; // system clock rate in kHz
  localparam int LCTS_TMIN_MS = 20; // teach pulse must be longer than this
  localparam int LCTS_TMAX_MS = 80; // teach pulse must be shorter than this
  localparam int LCTS_TMIN_CYC = LCTS_TMIN_MS * LCTS_CLK_KHZ; // least width, cycles
  localparam int LCTS_TMAX_CYC = LCTS_TMAX_MS * LCTS_CLK_KHZ; // longest width, cycles
  localparam int LCTS_CNT_W = 25; // width counter, holds the 80 ms count

  // ****************************************
  // beams and blanking
  // ****************************************
  localparam int LCTS_BEAMS = 16; // beams in the array
  localparam int LCTS_MARGIN = 1; // extra beams added on each side of a blocked run
  localparam logic [2:0] LCTS_MAX_AREAS = 3'h4; // most blanking areas
  localparam logic [7:0] LCTS_LEVEL_FULL = 8'hff; // bar level after a good teach
  localparam logic [7:0] LCTS_LEVEL_NONE = 8'h00; // no bar after a failed teach
  localparam logic [7:0] LCTS_GAIN_MAX = 8'hff; // top of the regulation range

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] LCTS_OFS_CTRL = 8'h00; // write: teach command
  localparam logic [7:0] LCTS_OFS_STAT = 8'h04; // read: busy, ok, error, display
  localparam logic [7:0] LCTS_OFS_CFG = 8'h08; // read/write: configuration
  localparam logic [7:0] LCTS_OFS_DEACT = 8'h0c; // read: deactivated beam mask
  localparam logic [7:0] LCTS_OFS_LEVEL = 8'h10; // read: last level, first level
  localparam logic [7:0] LCTS_OFS_GAIN = 8'h14; // read: regulated gain
  localparam int LCTS_CTRL_TEACH = 0; // teach command bit in the control word
  localparam logic [7:0] LCTS_CFG_RST = 8'h00; // non-volatile, positive, line one, no areas

  // configuration word, low byte of the config register
  typedef struct packed {
    logic [1:0] reserve; // function reserve step handed to the optics
    logic line_two; // 0: config_line_one is the teach input
    logic negative_switching; // 0: positive_switching, input active high
    logic store_volatile; // 0: keep taught values in non-volatile storage
    logic [2:0] areas; // number of blanking areas, 0 to 4
  } lcts_cfg_t;

  // classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lcts_wb_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_REG, ST_EVAL} lcts_fsm_t;

  // complete state of the sequencer
  typedef struct packed {
    lcts_fsm_t fsm;
    lcts_cfg_t cfg;
    logic [LCTS_CNT_W-1:0] pw_cnt;
    logic line_prev;
    logic pu_done;
    logic from_align;
    logic disp_align;
    logic teach_ok;
    logic teach_err;
    logic nv_store;
    logic [7:0] gain;
    logic [7:0] first_lvl;
    logic [7:0] last_lvl;
    logic [LCTS_BEAMS-1:0] deact;
    logic ack;
    logic [31:0] rdat;
  } lcts_regs_t;

endpackage

// ===== verification/lcts_plc_model.sv
// Purpose: controller model driving one teach line with pulses of a given width
// Assumes: pulse width counted in system clock cycles
// Notes: line is always driven to a level, never released
`timescale 1ns/1ps
module lcts_plc_model (
  input wire logic clk_i,
  input wire logic go_i, // one-cycle request to send a pulse
  input wire logic [7:0] width_i, // active cycles of the pulse
  input wire logic neg_i, // 1: negative switching, line idles high
  output logic line_o
);
  // *****
  // pulse timer
  // *****
  logic [7:0] left; // active cycles still to drive
  initial left = 8'h00;
  // a new request while a pulse runs is dropped, so widths never merge
  always @(posedge clk_i) begin
    if (go_i && left == 8'h00) left <= width_i;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  // active level follows the switching sense
  assign line_o = (left != 8'h00) ^ neg_i;
endmodule // lcts_plc_model

// ===== verification/testbench.sv
// Purpose: self-checking bench for the teach sequencer
// Assumes: short pulse window 20/80 cycles, optics modelled by a gain threshold
// Notes: driver notes expectations in queues, edge monitors compare them
`timescale 1ns/1ps
module testbench import lcts_pkg::*;;
  typedef struct packed {logic ok; logic disp; logic nv; logic [15:0] deact;} lcts_tb_note_t;
  logic clk_i = 1'b0, rst_i = 1'b1, panel = 1'b0, pu_en = 1'b0, align = 1'b0, corr = 1'b1;
  lcts_wb_req_t wb_req = '0;
  logic [31:0] wb_dat; logic wb_ack, busy, ok, err, disp, nv, busy_q = 1'b0, neg = 1'b0;
  logic [7:0] gain, lvl_f, lvl_l, width = 8'h00; logic [1:0] res_sel, line, go = 2'b00;
  logic [15:0] blocked = '0, deact, exp_deact = '0; logic [8:0] thr = 9'h010;
  int n_fail = 0, check_count = 0, n_res = 0;
  logic [31:0] q_rd[$]; lcts_tb_note_t q_res[$];
  always #2.5 clk_i = ~clk_i;
  // optics: every free beam reaches reserve once the gain reaches the threshold
  wire [15:0] at_res = ({1'b0, gain} >= thr) ? ~blocked : 16'h0000;
  lcts_sequencer #(.TEACH_MIN_CYC(20), .TEACH_MAX_CYC(80)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .io_line_i(line),
    .panel_teach_i(panel), .powerup_teach_en_i(pu_en), .align_mode_i(align),
    .beam_blocked_i(blocked), .at_reserve_i(at_res), .corridor_ok_i(corr), .gain_o(gain),
    .reserve_sel_o(res_sel), .deact_o(deact), .first_beam_level_o(lvl_f),
    .last_beam_level_o(lvl_l), .busy_o(busy), .teach_ok_o(ok), .teach_err_o(err),
    .align_display_o(disp), .nv_store_o(nv));
  // two controllers, one per configurable line
  lcts_plc_model plc0_u (.clk_i(clk_i), .go_i(go[0]), .width_i(width), .neg_i(neg),
    .line_o(line[0]));
  lcts_plc_model plc1_u (.clk_i(clk_i), .go_i(go[1]), .width_i(width), .neg_i(neg),
    .line_o(line[1]));
  // *****
  // checking
  // *****
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one finished teach against its note
  task automatic chk_res(input lcts_tb_note_t nt);
    chk("ok", nt.ok, ok);
    chk("err", !nt.ok, err);
    chk("first", nt.ok ? LCTS_LEVEL_FULL : LCTS_LEVEL_NONE, lvl_f);
    chk("last", nt.ok ? LCTS_LEVEL_FULL : LCTS_LEVEL_NONE, lvl_l);
    chk("disp", nt.disp, disp);
    chk("deact", nt.deact, deact);
    if (nt.ok) chk("nv", nt.nv, nv);
  endtask
  // read data is taken at the rising edge at which ack is sampled high
  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && wb_req.cyc === 1'b1 && wb_req.we === 1'b0) begin
      if (q_rd.size() == 0) chk("rd_extra", 0, 1);
      else chk("rd_data", q_rd.pop_front(), wb_dat);
    end
  end
  // teach results at negedge, where the edge's updates have landed
  always @(negedge clk_i) begin
    if (busy_q === 1'b1 && busy === 1'b0) begin
      n_res++;
      if (q_res.size() == 0) chk("teach_extra", 0, 1);
      else chk_res(q_res.pop_front());
    end
    busy_q = busy;
  end
  // *****
  // drivers
  // *****
  // classic single cycle, held until ack is sampled, one idle cycle after
  task automatic wbx(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    if (i == 50) chk("wb_ack", 1, 0);
    wb_req <= '0;
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    q_rd.push_back(exp);
    wbx(1'b0, adr, 32'h0);
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    exp_deact = '0;
  endtask
  task automatic press();
    @(posedge clk_i) panel <= 1'b1;
    @(posedge clk_i) panel <= 1'b0;
  endtask
  task automatic pulse(input int which, input logic [7:0] w);
    @(posedge clk_i);
    width <= w;
    go[which] <= 1'b1;
    @(posedge clk_i) go <= 2'b00;
  endtask
  // note the result, then wait for it under a bound
  task automatic finish_teach(input logic t_ok, input logic t_disp, input logic t_nv);
    int n0;
    int i;
    n0 = n_res;
    q_res.push_back('{ok: t_ok, disp: t_disp, nv: t_nv, deact: exp_deact});
    for (i = 0; i < 1000 && n_res == n0; i++) @(posedge clk_i);
    chk("teach_done", n0 + 1, n_res);
  endtask
  // pulse that must not start a teach
  task automatic no_teach(input int which, input logic [7:0] w);
    int n0;
    n0 = n_res;
    pulse(which, w);
    // long enough for a wrongly started teach to finish and be counted
    repeat (w + 40) @(posedge clk_i);
    chk("ignored", n0, n_res);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    conclude();
  end
  // *****
  // scenarios
  // *****
  initial begin
    void'($urandom(32'ha2fa));
    do_reset();
    repeat (20) @(posedge clk_i);
    chk("pu_off", 0, n_res);
    rd(LCTS_OFS_CFG, 32'h0);
    rd(8'h20, 32'h0);
    wbx(1'b1, 8'h24, 32'hffffffff);
    thr <= 9'(32'd1 + ($urandom % 32'd200));
    press();
    finish_teach(1'b1, 1'b0, 1'b1);
    rd(LCTS_OFS_GAIN, {23'h0, thr});
    rd(LCTS_OFS_STAT, 32'h2);
    align <= 1'b1;
    wbx(1'b1, LCTS_OFS_CTRL, 32'h1);
    finish_teach(1'b1, 1'b1, 1'b1);
    rd(LCTS_OFS_LEVEL, 32'hffff);
    thr <= 9'h100;
    press();
    finish_teach(1'b0, 1'b1, 1'b0);
    thr <= 9'h010;
    corr <= 1'b0;
    press();
    finish_teach(1'b0, 1'b1, 1'b0);
    corr <= 1'b1;
    align <= 1'b0;
    blocked <= 16'h0008;
    press();
    finish_teach(1'b0, 1'b0, 1'b0);
    wbx(1'b1, LCTS_OFS_CFG, 32'h89);
    chk("reserve", 2'b10, res_sel);
    blocked <= 16'h0060;
    exp_deact = 16'h00f0;
    press();
    finish_teach(1'b1, 1'b0, 1'b0);
    rd(LCTS_OFS_DEACT, 32'h00f0);
    wbx(1'b1, LCTS_OFS_CFG, 32'h07);
    rd(LCTS_OFS_CFG, 32'h04);
    blocked <= 16'h4444;
    exp_deact = 16'heeee;
    press();
    finish_teach(1'b1, 1'b0, 1'b1);
    blocked <= 16'h0155;
    press();
    finish_teach(1'b0, 1'b0, 1'b0);
    blocked <= '0;
    exp_deact = '0;
    wbx(1'b1, LCTS_OFS_CFG, 32'h0);
    no_teach(0, 8'd20);
    pulse(0, 8'd21);
    finish_teach(1'b1, 1'b0, 1'b1);
    pulse(0, 8'd79);
    finish_teach(1'b1, 1'b0, 1'b1);
    no_teach(0, 8'd80);
    no_teach(1, 8'd40);
    wbx(1'b1, LCTS_OFS_CFG, 32'h10);
    neg <= 1'b1;
    repeat (5) @(posedge clk_i);
    pulse(0, 8'd50);
    finish_teach(1'b1, 1'b0, 1'b1);
    neg <= 1'b0;
    pu_en <= 1'b1;
    do_reset();
    finish_teach(1'b1, 1'b0, 1'b1);
    conclude();
  end
endmodule // testbench

// ===== verilog/lcts_sequencer.sv
// Purpose: teach sequencer; levels beams, learns blanking, reports bar levels
// Assumes: all inputs synchronous to clk_i; optics report per-beam reserve and corridor
// Notes: teach starts from panel, teach line, register command or power-up
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps

module lcts_sequencer import lcts_pkg::*; #(
  parameter int TEACH_MIN_CYC = LCTS_TMIN_CYC, // least pulse width, cycles
  parameter int TEACH_MAX_CYC = LCTS_TMAX_CYC // longest pulse width, cycles
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire lcts_wb_req_t wb_req_i, // wishbone request
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [1:0] io_line_i, // configurable lines, bit 0 is config_line_one
  input wire logic panel_teach_i, // one-cycle teach command from the front panel
  input wire logic powerup_teach_en_i, // power-up teach setting, read once after reset
  input wire logic align_mode_i, // 1: alignment mode, 0: process mode
  input wire logic [LCTS_BEAMS-1:0] beam_blocked_i, // beam interrupted
  input wire logic [LCTS_BEAMS-1:0] at_reserve_i, // beam at the requested reserve
  input wire logic corridor_ok_i, // all beam signals inside one corridor
  output logic [7:0] gain_o, // regulation step for transmitter and receiver
  output logic [1:0] reserve_sel_o, // requested function reserve
  output logic [LCTS_BEAMS-1:0] deact_o, // deactivated beams
  output logic [7:0] first_beam_level_o, // first beam bar level
  output logic [7:0] last_beam_level_o, // last beam bar level
  output logic busy_o, // teach running, display shows waiting
  output logic teach_ok_o, // last teach succeeded
  output logic teach_err_o, // last teach failed
  output logic align_display_o, // 1: bar graph, 0: process display
  output logic nv_store_o // one-cycle request to save taught values
);

  // ****************************************
  // declarations
  // ****************************************
  localparam logic [LCTS_CNT_W-1:0] MIN_C = LCTS_CNT_W'(TEACH_MIN_CYC); // width floor
  localparam logic [LCTS_CNT_W-1:0] MAX_C = LCTS_CNT_W'(TEACH_MAX_CYC); // width ceiling
  lcts_regs_t st; // present state
  lcts_regs_t next_st; // next state
  logic line_act; // teach line in its active sense
  logic line_req; // valid teach pulse just ended
  logic pu_req; // power-up teach request
  logic bus_acc; // new bus access this cycle
  logic bus_teach; // teach command written over the bus
  logic teach_req; // any teach source
  logic all_ready; // every counted beam reached the reserve
  logic [4:0] runs; // number of blocked runs
  logic blank_ok; // blocked beams fit the configured areas
  logic eval_ok; // result of the evaluation step
  logic [LCTS_BEAMS-1:0] widened; // blocked beams plus margin

  // ****************************************
  // blanking analysis
  // ****************************************
  // widen each blocked beam by the margin on both sides
  genvar g;
  generate
    for (g = 0; g < LCTS_BEAMS; g++) begin : g_widen
      localparam int LO = (g - LCTS_MARGIN < 0) ? 0 : g - LCTS_MARGIN;
      localparam int HI = (g + LCTS_MARGIN > LCTS_BEAMS - 1) ? LCTS_BEAMS - 1 : g + LCTS_MARGIN;
      assign widened[g] = |beam_blocked_i[HI:LO];
    end
  endgenerate

  // count runs of adjacent blocked beams; each run needs one area
  always_comb begin
    runs = 5'h00;
    for (int i = 0; i < LCTS_BEAMS; i++) begin
      if (beam_blocked_i[i] && (i == 0 || !beam_blocked_i[(i == 0) ? 0 : i - 1])) begin
        runs = runs + 5'h01;
      end
    end
  end

  // without areas the light path must be clear; with areas runs must fit
  assign blank_ok = (st.cfg.areas == 3'h0) ? !(|beam_blocked_i)
                                            : (runs <= {2'h0, st.cfg.areas});
  // blocked beams cannot reach the reserve, so regulation waits for the free beams only;
  // without areas a blocked beam is then judged by the evaluation step instead of
  // running the gain into its ceiling, which would look like a weak signal
  assign all_ready = &(at_reserve_i | beam_blocked_i);
  assign eval_ok = corridor_ok_i && blank_ok;

  // ****************************************
  // teach sources
  // ****************************************
  // selected line, inverted for negative switching
  assign line_act = (st.cfg.line_two ? io_line_i[1] : io_line_i[0])
                    ^ st.cfg.negative_switching;
  // a pulse counts only when its width lies strictly inside the window
  assign line_req = st.line_prev && !line_act && (st.pw_cnt > MIN_C)
                    && (st.pw_cnt < MAX_C);
  assign pu_req = !st.pu_done && powerup_teach_en_i;
  assign bus_acc = wb_req_i.cyc && wb_req_i.stb && !st.ack;
  assign bus_teach = bus_acc && wb_req_i.we && (wb_req_i.adr == LCTS_OFS_CTRL)
                     && wb_req_i.sel[0] && wb_req_i.dat[LCTS_CTRL_TEACH];
  assign teach_req = line_req || pu_req || panel_teach_i || bus_teach;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.nv_store = 1'b0;
    next_st.pu_done = 1'b1;
    next_st.line_prev = line_act;
    // width counter saturates so an overlong pulse cannot wrap into the window
    if (line_act) begin
      if (st.pw_cnt != MAX_C) begin
        next_st.pw_cnt = st.pw_cnt + LCTS_CNT_W'(1);
      end
    end else begin
      next_st.pw_cnt = '0;
    end
    // bus slave: answer one cycle after the request, unmapped reads give zero
    if (bus_acc) begin
      next_st.ack = 1'b1;
      next_st.rdat = 32'h0000_0000;
      if (wb_req_i.we) begin
        if (wb_req_i.adr == LCTS_OFS_CFG && wb_req_i.sel[0]) begin
          next_st.cfg = lcts_cfg_t'(wb_req_i.dat[7:0]);
          // clamp so the area count never exceeds the supported maximum
          if (wb_req_i.dat[2:0] > LCTS_MAX_AREAS) begin
            next_st.cfg.areas = LCTS_MAX_AREAS;
          end
        end
      end else begin
        case (wb_req_i.adr)
          LCTS_OFS_STAT: next_st.rdat = {28'h0, st.disp_align, st.teach_err, st.teach_ok,
                                         st.fsm != ST_IDLE};
          LCTS_OFS_CFG: next_st.rdat = {24'h0, st.cfg};
          LCTS_OFS_DEACT: next_st.rdat = {16'h0, st.deact};
          LCTS_OFS_LEVEL: next_st.rdat = {16'h0, st.last_lvl, st.first_lvl};
          LCTS_OFS_GAIN: next_st.rdat = {24'h0, st.gain};
          default: next_st.rdat = 32'h0000_0000;
        endcase
      end
    end
    // sequencer
    case (st.fsm)
      ST_IDLE: begin
        next_st.disp_align = align_mode_i;
        // requests are taken in either display mode
        if (teach_req) begin
          next_st.fsm = ST_REG;
          next_st.from_align = align_mode_i;
          next_st.gain = 8'h00;
          next_st.teach_ok = 1'b0;
          next_st.teach_err = 1'b0;
        end
      end
      ST_REG: begin
        // raise the gain one step a cycle until every counted beam holds the reserve
        if (all_ready) begin
          next_st.fsm = ST_EVAL;
        end else if (st.gain == LCTS_GAIN_MAX) begin
          // signal too low: out of range without reaching the reserve
          next_st.fsm = ST_IDLE;
          next_st.teach_err = 1'b1;
          next_st.first_lvl = LCTS_LEVEL_NONE;
          next_st.last_lvl = LCTS_LEVEL_NONE;
          next_st.disp_align = st.from_align;
        end else begin
          next_st.gain = st.gain + 8'h01;
        end
      end
      ST_EVAL: begin
        next_st.fsm = ST_IDLE;
        next_st.disp_align = st.from_align;
        if (eval_ok) begin
          next_st.teach_ok = 1'b1;
          next_st.first_lvl = LCTS_LEVEL_FULL;
          next_st.last_lvl = LCTS_LEVEL_FULL;
          next_st.deact = (st.cfg.areas == 3'h0) ? '0 : widened;
          next_st.nv_store = !st.cfg.store_volatile;
        end else begin
          next_st.teach_err = 1'b1;
          next_st.first_lvl = LCTS_LEVEL_NONE;
          next_st.last_lvl = LCTS_LEVEL_NONE;
        end
      end
      default: next_st.fsm = ST_IDLE;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  // synchronous reset to constants only; the power-up strap is read after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.fsm <= ST_IDLE;
      st.cfg <= lcts_cfg_t'(LCTS_CFG_RST);
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign wb_dat_o = st.rdat;
  assign wb_ack_o = st.ack;
  assign gain_o = st.gain;
  assign reserve_sel_o = st.cfg.reserve;
  assign deact_o = st.deact;
  assign first_beam_level_o = st.first_lvl;
  assign last_beam_level_o = st.last_lvl;
  assign busy_o = (st.fsm != ST_IDLE);
  assign teach_ok_o = st.teach_ok;
  assign teach_err_o = st.teach_err;
  assign align_display_o = st.disp_align;
  assign nv_store_o = st.nv_store;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_line_start;
    (st.fsm == ST_IDLE && line_req) |=> busy_o ##1 busy_o;
  endproperty
  a_line_start: assert property (p_line_start) else $error("valid pulse did not start teach");

  property p_short_ignored;
    (st.fsm == ST_IDLE && st.line_prev && !line_act && st.pw_cnt <= MIN_C && !panel_teach_i
     && !pu_req && !bus_teach) |=> !busy_o;
  endproperty
  a_short_ignored: assert property (p_short_ignored) else $error("short pulse started teach");

  property p_ok_levels;
    (st.fsm == ST_EVAL && eval_ok) |=> teach_ok_o && first_beam_level_o == 8'hff
                                       && last_beam_level_o == 8'hff;
  endproperty
  a_ok_levels: assert property (p_ok_levels) else $error("good teach without full levels");

  property p_err_levels;
    $rose(teach_err_o) |-> first_beam_level_o == 8'h00 && last_beam_level_o == 8'h00;
  endproperty
  a_err_levels: assert property (p_err_levels) else $error("failed teach shows a level");

  property p_clear_path;
    (st.fsm == ST_EVAL && st.cfg.areas == 3'h0 && |beam_blocked_i) |=> teach_err_o && !busy_o;
  endproperty
  a_clear_path: assert property (p_clear_path) else $error("blocked beam passed teach");

  property p_blank_mask;
    (st.fsm == ST_EVAL && eval_ok && st.cfg.areas != 3'h0) |=> deact_o == $past(widened);
  endproperty
  a_blank_mask: assert property (p_blank_mask) else $error("deactivated mask wrong");

  property p_area_limit;
    (st.fsm == ST_EVAL && st.cfg.areas != 3'h0 && runs > {2'h0, st.cfg.areas}) |=> teach_err_o;
  endproperty
  a_area_limit: assert property (p_area_limit) else $error("too many runs accepted");

  property p_store;
    (st.fsm == ST_EVAL) |=> nv_store_o == ($past(eval_ok) && !$past(st.cfg.store_volatile))
                            ##1 !nv_store_o;
  endproperty
  a_store: assert property (p_store) else $error("storage request wrong");

  property p_return_mode;
    (busy_o && !next_st.fsm[0] && !next_st.fsm[1]) |=> align_display_o == $past(st.from_align);
  endproperty
  a_return_mode: assert property (p_return_mode) else $error("wrong display after teach");

  property p_busy_regulate;
    $rose(busy_o) |-> busy_o throughout (gain_o == 8'h00 ##1 1'b1);
  endproperty
  a_busy_regulate: assert property (p_busy_regulate) else $error("busy not held");

  // power-up teach starts in the first cycle after reset when the setting is on
  property p_powerup;
    (!st.pu_done && powerup_teach_en_i) |=> busy_o;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up teach not started");

  c_ok_align: cover property ($rose(teach_ok_o) && align_display_o);
  c_ok_blank: cover property ($rose(teach_ok_o) && |deact_o);
  c_err: cover property ($rose(teach_err_o));
  c_line: cover property (line_req && st.fsm == ST_IDLE);

endmodule // lcts_sequencer
